// ==== fbs_boot_timer.sv ====
// Power-up readiness timer counting whole milliseconds of the system clock.
`timescale 1ns/1ps
`default_nettype none

module fbs_boot_timer #(
	parameter int unsigned CYCLES_PER_MS = fbs_pkg::CYCLES_PER_MS
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [31:0] delay_ms,
	output logic             ready
);

	localparam int unsigned CW = $clog2(CYCLES_PER_MS + 1);

	typedef enum logic {FBS_BT_WAIT, FBS_BT_READY} fbs_bt_state_t;

	generate
		if (CYCLES_PER_MS < 1) begin : g_bad_rate
			$error("CYCLES_PER_MS must be at least one");
		end
	endgenerate

	fbs_bt_state_t state_r;
	fbs_bt_state_t state_nxt;
	logic [CW-1:0] cyc_r;
	logic [CW-1:0] cyc_nxt;
	logic [31:0]   ms_r;
	logic [31:0]   ms_nxt;
	logic          ready_r;
	logic          ready_nxt;

	// The delay is compared live, so a new value written before readiness still counts;
	// once ready the flag holds until the next reset.
	always_comb begin
		state_nxt = state_r;
		cyc_nxt   = cyc_r;
		ms_nxt    = ms_r;
		case (state_r)
			FBS_BT_WAIT: begin
				if (ms_r >= delay_ms) begin
					state_nxt = FBS_BT_READY;
				end else if (cyc_r == CW'(CYCLES_PER_MS - 1)) begin
					cyc_nxt = '0;
					ms_nxt  = ms_r + 32'h00000001;
				end else begin
					cyc_nxt = cyc_r + CW'(1);
				end
			end
			FBS_BT_READY: begin
				state_nxt = FBS_BT_READY;
			end
			default: begin
				state_nxt = FBS_BT_WAIT;
			end
		endcase
		ready_nxt = (state_nxt == FBS_BT_READY);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_r <= FBS_BT_WAIT;
			cyc_r   <= '0;
			ms_r    <= 32'h00000000;
			ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cyc_r   <= cyc_nxt;
			ms_r    <= ms_nxt;
			ready_r <= ready_nxt;
		end
	end

	assign ready = ready_r;

endmodule

`default_nettype wire

// ==== fbs_link_model.sv ====
// Link-side source of bus state code, error and synchronization levels.
`timescale 1ns/1ps
`default_nettype none

module fbs_link_model (
	input  wire logic       clk_sys,
	input  wire logic [2:0] sel,
	input  wire logic       err,
	input  wire logic       sync,
	output logic [3:0]      bus_state_field,
	output logic            bus_error_in,
	output logic            clock_sync_in
);
	// Only the documented state codes are ever produced, as a real link would.
	always_ff @(posedge clk_sys) begin
		case (sel)
			3'h0: bus_state_field <= 4'h1;
			3'h1: bus_state_field <= 4'h2;
			3'h2: bus_state_field <= 4'h3;
			3'h3: bus_state_field <= 4'h4;
			default: bus_state_field <= 4'h8;
		endcase
		bus_error_in <= err;
		clock_sync_in <= sync;
	end
endmodule
`default_nettype wire

// ==== fbs_pkg.sv ====
// Constants for the fieldbus select and status dictionary bank.
package fbs_pkg;

	// Dictionary object indices.
	localparam logic [15:0] IDX_BOOTUP_DELAY    = 16'h2084;
	localparam logic [15:0] IDX_FB_AVAIL        = 16'h2101;
	localparam logic [15:0] IDX_FB_CONTROL      = 16'h2102;
	localparam logic [15:0] IDX_FB_STATUS       = 16'h2103;
	localparam logic [15:0] IDX_SLAVE_STATE     = 16'h2110;
	localparam logic [15:0] IDX_DRV_CONTROL     = 16'h2290;
	localparam logic [15:0] IDX_DRV_INPUT       = 16'h2291;

	// Subindices.
	localparam logic [7:0]  SUB_COUNT           = 8'h00;
	localparam logic [7:0]  SUB_DISABLE_MASK    = 8'h01;
	localparam logic [7:0]  SUB_ENABLED         = 8'h02;
	localparam logic [7:0]  SUB_SET_VALUE1      = 8'h01;
	localparam logic [7:0]  SUB_SET_VALUE2      = 8'h02;
	localparam logic [7:0]  SUB_SET_VALUE3      = 8'h03;
	localparam logic [7:0]  SUB_COMMAND         = 8'h04;

	// Entry counts of the array and the record.
	localparam logic [7:0]  FB_STATUS_COUNT     = 8'h02;
	localparam logic [7:0]  DRV_INPUT_COUNT     = 8'h04;

	// Interface map bit positions: physical interfaces low, protocols high.
	localparam int unsigned USB_PORT_BIT             = 0;
	localparam int unsigned RS485_PORT_BIT           = 1;
	localparam int unsigned RS232_PORT_BIT           = 2;
	localparam int unsigned CAN_PORT_BIT             = 3;
	localparam int unsigned ETHERNET_PORT_BIT        = 4;
	localparam int unsigned INDUSTRIAL_ETH_SLAVE_BIT = 5;
	localparam int unsigned SPI_PORT_BIT             = 6;
	localparam int unsigned MODBUS_SERIAL_PROTO_BIT  = 16;
	localparam int unsigned MODBUS_IP_PROTO_BIT      = 17;
	localparam int unsigned INDUSTRIAL_IP_PROTO_BIT  = 18;
	localparam logic [31:0] PHYS_FIELD_MASK     = 32'h0000FFFF;
	localparam logic [31:0] PROTO_FIELD_MASK    = 32'hFFFF0000;
	localparam logic [31:0] MAP_VALID_BITS      = 32'h0007007F;

	// Values after reset.
	localparam logic [31:0] BOOTUP_DELAY_RST    = 32'h00000000;
	localparam logic [31:0] FB_AVAIL_RST        = 32'h00000020;
	localparam logic [31:0] FB_CONTROL_RST      = 32'h00000020;
	localparam logic [31:0] FB_DISABLE_MASK_RST = 32'h00000000;
	localparam logic [31:0] FB_ENABLED_RST      = 32'h00000020;
	localparam logic [15:0] SLAVE_STATE_RST     = 16'h0000;
	localparam logic [7:0]  DRV_CONTROL_RST     = 8'h01;
	localparam logic [31:0] DRV_VALUE1_RST      = 32'h00000000;
	localparam logic [15:0] DRV_VALUE2_RST      = 16'h0000;
	localparam logic [7:0]  DRV_VALUE3_RST      = 8'h00;
	localparam logic [7:0]  DRV_COMMAND_RST     = 8'h00;

	// Slave state word layout.
	localparam int unsigned BUS_STATE_LSB       = 0;
	localparam int unsigned BUS_STATE_W         = 4;
	localparam int unsigned BUS_ERROR_BIT       = 4;
	localparam int unsigned CLOCK_SYNC_BIT      = 5;
	localparam logic [3:0]  BUS_ST_INIT         = 4'h1;
	localparam logic [3:0]  BUS_ST_PREOP        = 4'h2;
	localparam logic [3:0]  BUS_ST_BOOT         = 4'h3;
	localparam logic [3:0]  BUS_ST_SAFEOP       = 4'h4;
	localparam logic [3:0]  BUS_ST_OP           = 4'h8;

	// Drive interface control layout.
	localparam int unsigned DRV_ENABLE_BIT      = 0;

	// Timing: the boot delay counts in milliseconds of the system clock.
	localparam int unsigned CLK_PERIOD_NS       = 10;
	localparam int unsigned MS_IN_NS            = 1000000;
	localparam int unsigned CYCLES_PER_MS       = MS_IN_NS / CLK_PERIOD_NS;

endpackage

// ==== fbs_regs.sv ====
// Fieldbus select, status and drive interface dictionary entries.
//
// Behaviour
// - Boot delay is 32-bit read/write milliseconds before readiness, reset zero.
// - Map words: low sixteen bits physical interfaces, high sixteen bits protocols.
// - Fixed bit positions for each interface and protocol in every map word.
// - Availability word is read-only; default only the industrial slave bit.
// - Read-only disable mask marks what control may deactivate; default zero.
// - Read-only enabled word shows active interfaces; default industrial slave bit.
// - Status array reports two entries, then disable mask and enabled word.
// - Slave state word holds a 4-bit bus state code.
// - Slave state word error flag reads one while a bus error is active.
// - Slave state word sync flag reads one while clock synchronization runs.
`timescale 1ns/1ps
`default_nettype none

module fbs_regs #(
	parameter int unsigned CYCLES_PER_MS = fbs_pkg::CYCLES_PER_MS,
	parameter logic [31:0] AVAIL_BITS    = fbs_pkg::FB_AVAIL_RST,
	parameter logic [31:0] DISABLE_MASK  = fbs_pkg::FB_DISABLE_MASK_RST
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        od_req,
	input  wire logic        od_write,
	input  wire logic [15:0] od_index,
	input  wire logic [7:0]  od_subindex,
	input  wire logic [31:0] od_wdata,
	output logic             od_ack,
	output logic             od_abort,
	output logic [31:0]      od_rdata,
	input  wire logic [3:0]  bus_state_field,
	input  wire logic        bus_error_in,
	input  wire logic        clock_sync_in,
	output logic             operational_ready,
	output logic [31:0]      fieldbus_enabled,
	output logic             drive_iface_en,
	output logic [31:0]      drive_set_value1,
	output logic [15:0]      drive_set_value2,
	output logic [7:0]       drive_set_value3,
	output logic [7:0]       drive_command_byte,
	output logic             drive_command_pulse
);

	generate
		if ((AVAIL_BITS & ~fbs_pkg::MAP_VALID_BITS) != 32'h00000000) begin : g_bad_avail
			$error("AVAIL_BITS sets a bit with no assigned interface");
		end
		if ((DISABLE_MASK & ~AVAIL_BITS) != 32'h00000000) begin : g_bad_mask
			$error("DISABLE_MASK names an interface that is not available");
		end
	endgenerate

	// Stored state.
	logic [31:0] boot_r;
	logic [31:0] boot_nxt;
	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;
	logic [31:0] enabled_r;
	logic [31:0] enabled_nxt;
	logic [15:0] slave_r;
	logic [15:0] slave_nxt;
	logic [7:0]  drv_ctrl_r;
	logic [7:0]  drv_ctrl_nxt;
	logic [31:0] val1_r;
	logic [31:0] val1_nxt;
	logic [15:0] val2_r;
	logic [15:0] val2_nxt;
	logic [7:0]  val3_r;
	logic [7:0]  val3_nxt;
	logic [7:0]  cmd_r;
	logic [7:0]  cmd_nxt;
	logic        cmd_pulse_r;
	logic        cmd_pulse_nxt;
	logic        ack_r;
	logic        ack_nxt;
	logic        abort_r;
	logic        abort_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        drv_en_r;
	logic        drv_en_nxt;

	// Decode results.
	logic        hit;
	logic        writable;
	logic [31:0] rd_val;
	logic        do_write;

	fbs_boot_timer #(
		.CYCLES_PER_MS (CYCLES_PER_MS)
	) u_boot_timer (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.delay_ms (boot_r),
		.ready    (operational_ready)
	);

	// Object decode: finds the entry, its read value and whether it takes writes.
	always_comb begin
		hit      = 1'b0;
		writable = 1'b0;
		rd_val   = 32'h00000000;
		case (od_index)
			fbs_pkg::IDX_BOOTUP_DELAY: begin
				if (od_subindex == fbs_pkg::SUB_COUNT) begin
					hit      = 1'b1;
					writable = 1'b1;
					rd_val   = boot_r;
				end
			end
			fbs_pkg::IDX_FB_AVAIL: begin
				if (od_subindex == fbs_pkg::SUB_COUNT) begin
					hit    = 1'b1;
					rd_val = AVAIL_BITS & fbs_pkg::MAP_VALID_BITS;
				end
			end
			fbs_pkg::IDX_FB_CONTROL: begin
				if (od_subindex == fbs_pkg::SUB_COUNT) begin
					hit      = 1'b1;
					writable = 1'b1;
					rd_val   = ctrl_r;
				end
			end
			fbs_pkg::IDX_FB_STATUS: begin
				case (od_subindex)
					fbs_pkg::SUB_COUNT: begin
						hit    = 1'b1;
						rd_val = {24'h000000, fbs_pkg::FB_STATUS_COUNT};
					end
					fbs_pkg::SUB_DISABLE_MASK: begin
						hit    = 1'b1;
						rd_val = DISABLE_MASK & fbs_pkg::MAP_VALID_BITS;
					end
					fbs_pkg::SUB_ENABLED: begin
						hit    = 1'b1;
						rd_val = enabled_r;
					end
					default: begin
						hit = 1'b0;
					end
				endcase
			end
			fbs_pkg::IDX_SLAVE_STATE: begin
				if (od_subindex == fbs_pkg::SUB_COUNT) begin
					hit    = 1'b1;
					rd_val = {16'h0000, slave_r};
				end
			end
			fbs_pkg::IDX_DRV_CONTROL: begin
				if (od_subindex == fbs_pkg::SUB_COUNT) begin
					hit      = 1'b1;
					writable = 1'b1;
					rd_val   = {24'h000000, drv_ctrl_r};
				end
			end
			fbs_pkg::IDX_DRV_INPUT: begin
				hit      = 1'b1;
				writable = 1'b1;
				case (od_subindex)
					fbs_pkg::SUB_COUNT: begin
						writable = 1'b0;
						rd_val   = {24'h000000, fbs_pkg::DRV_INPUT_COUNT};
					end
					fbs_pkg::SUB_SET_VALUE1: rd_val = val1_r;
					fbs_pkg::SUB_SET_VALUE2: rd_val = {{16{val2_r[15]}}, val2_r};
					fbs_pkg::SUB_SET_VALUE3: rd_val = {{24{val3_r[7]}}, val3_r};
					fbs_pkg::SUB_COMMAND:    rd_val = {{24{cmd_r[7]}}, cmd_r};
					default: begin
						hit      = 1'b0;
						writable = 1'b0;
					end
				endcase
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	assign do_write = od_req && od_write && hit && writable;

	// Next values of the stored entries and the one-cycle answer.
	always_comb begin
		boot_nxt      = boot_r;
		ctrl_nxt      = ctrl_r;
		drv_ctrl_nxt  = drv_ctrl_r;
		val1_nxt      = val1_r;
		val2_nxt      = val2_r;
		val3_nxt      = val3_r;
		cmd_nxt       = cmd_r;
		cmd_pulse_nxt = 1'b0;
		ack_nxt       = od_req;
		abort_nxt     = od_req && (!hit || (od_write && !writable));
		rdata_nxt     = 32'h00000000;
		if (od_req && !od_write && hit) begin
			rdata_nxt = rd_val;
		end
		if (do_write) begin
			case (od_index)
				fbs_pkg::IDX_BOOTUP_DELAY: boot_nxt = od_wdata;
				fbs_pkg::IDX_FB_CONTROL: begin
					// Unassigned map bits are dropped so they always read back zero.
					ctrl_nxt = od_wdata & fbs_pkg::MAP_VALID_BITS;
				end
				fbs_pkg::IDX_DRV_CONTROL: drv_ctrl_nxt = od_wdata[7:0];
				fbs_pkg::IDX_DRV_INPUT: begin
					case (od_subindex)
						fbs_pkg::SUB_SET_VALUE1: val1_nxt = od_wdata;
						fbs_pkg::SUB_SET_VALUE2: val2_nxt = od_wdata[15:0];
						fbs_pkg::SUB_SET_VALUE3: val3_nxt = od_wdata[7:0];
						fbs_pkg::SUB_COMMAND: begin
							cmd_nxt       = od_wdata[7:0];
							cmd_pulse_nxt = 1'b1;
						end
						default: begin
							cmd_pulse_nxt = 1'b0;
						end
					endcase
				end
				default: begin
					cmd_pulse_nxt = 1'b0;
				end
			endcase
		end
	end

	// Derived status: an interface is active when present and either not switchable
	// or switched on. Using the committed control word costs one cycle of lag after a write.
	always_comb begin
		enabled_nxt = AVAIL_BITS & fbs_pkg::MAP_VALID_BITS
			& (ctrl_r | ~DISABLE_MASK);
		slave_nxt   = fbs_pkg::SLAVE_STATE_RST;
		slave_nxt[fbs_pkg::BUS_STATE_LSB +: fbs_pkg::BUS_STATE_W] = bus_state_field;
		slave_nxt[fbs_pkg::BUS_ERROR_BIT]  = bus_error_in;
		slave_nxt[fbs_pkg::CLOCK_SYNC_BIT] = clock_sync_in;
		drv_en_nxt  = drv_ctrl_r[fbs_pkg::DRV_ENABLE_BIT];
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			boot_r      <= fbs_pkg::BOOTUP_DELAY_RST;
			ctrl_r      <= fbs_pkg::FB_CONTROL_RST;
			enabled_r   <= fbs_pkg::FB_ENABLED_RST;
			slave_r     <= fbs_pkg::SLAVE_STATE_RST;
			drv_ctrl_r  <= fbs_pkg::DRV_CONTROL_RST;
			val1_r      <= fbs_pkg::DRV_VALUE1_RST;
			val2_r      <= fbs_pkg::DRV_VALUE2_RST;
			val3_r      <= fbs_pkg::DRV_VALUE3_RST;
			cmd_r       <= fbs_pkg::DRV_COMMAND_RST;
			cmd_pulse_r <= 1'b0;
			ack_r       <= 1'b0;
			abort_r     <= 1'b0;
			rdata_r     <= 32'h00000000;
			drv_en_r    <= fbs_pkg::DRV_CONTROL_RST[fbs_pkg::DRV_ENABLE_BIT];
		end else begin
			boot_r      <= boot_nxt;
			ctrl_r      <= ctrl_nxt;
			enabled_r   <= enabled_nxt;
			slave_r     <= slave_nxt;
			drv_ctrl_r  <= drv_ctrl_nxt;
			val1_r      <= val1_nxt;
			val2_r      <= val2_nxt;
			val3_r      <= val3_nxt;
			cmd_r       <= cmd_nxt;
			cmd_pulse_r <= cmd_pulse_nxt;
			ack_r       <= ack_nxt;
			abort_r     <= abort_nxt;
			rdata_r     <= rdata_nxt;
			drv_en_r    <= drv_en_nxt;
		end
	end

	assign od_ack              = ack_r;
	assign od_abort            = abort_r;
	assign od_rdata            = rdata_r;
	assign fieldbus_enabled    = enabled_r;
	assign drive_iface_en      = drv_en_r;
	assign drive_set_value1    = val1_r;
	assign drive_set_value2    = val2_r;
	assign drive_set_value3    = val3_r;
	assign drive_command_byte  = cmd_r;
	assign drive_command_pulse = cmd_pulse_r;

endmodule

`default_nettype wire

// ==== fbs_regs_properties.sv ====
// Port checker for the fieldbus dictionary bank, bound to its top module.
`timescale 1ns/1ps
`default_nettype none

module fbs_regs_properties #(
	parameter int unsigned CYCLES_PER_MS = 4,
	parameter logic [31:0] AVAIL_BITS    = 32'h20,
	parameter logic [31:0] DISABLE_MASK  = 32'h0
) (
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        od_req,
	input wire logic        od_write,
	input wire logic [15:0] od_index,
	input wire logic [7:0]  od_subindex,
	input wire logic [31:0] od_wdata,
	input wire logic        od_ack,
	input wire logic        od_abort,
	input wire logic [31:0] od_rdata,
	input wire logic [3:0]  bus_state_field,
	input wire logic        bus_error_in,
	input wire logic        clock_sync_in,
	input wire logic        operational_ready,
	input wire logic [31:0] fieldbus_enabled,
	input wire logic        drive_iface_en,
	input wire logic [31:0] drive_set_value1,
	input wire logic [15:0] drive_set_value2,
	input wire logic [7:0]  drive_set_value3,
	input wire logic [7:0]  drive_command_byte,
	input wire logic        drive_command_pulse
);
	logic rd;
	logic wr;
	logic cmd_wr;
	assign rd = od_req && !od_write;
	assign wr = od_req && od_write;
	assign cmd_wr = wr && od_index == 16'h2291 && od_subindex == 8'h04;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	avail_read_a: assert property (rd && od_index == 16'h2101 && od_subindex == 8'h00
		|=> od_ack && !od_abort && od_rdata == AVAIL_BITS) else $error("availability read wrong");
	count_read_a: assert property (rd && od_index == 16'h2103 && od_subindex == 8'h00
		|=> od_ack && od_rdata == 32'h2) else $error("status count wrong");
	mask_read_a: assert property (rd && od_index == 16'h2103 && od_subindex == 8'h01
		|=> od_ack && od_rdata == DISABLE_MASK) else $error("disable mask wrong");
	status_ro_a: assert property (wr && od_index == 16'h2103
		|=> od_ack && od_abort) else $error("status write not refused");
	state_word_a: assert property (rd && od_index == 16'h2110 && od_subindex == 8'h00
		|=> od_rdata == {26'h0, $past(clock_sync_in, 2), $past(bus_error_in, 2),
		$past(bus_state_field, 2)}) else $error("slave state word wrong");
	map_bits_a: assert property ((fieldbus_enabled & ~(32'h0007007F & AVAIL_BITS)) == 32'h0)
		else $error("enabled word has unassigned bits");
	ready_hold_a: assert property (operational_ready |=> operational_ready)
		else $error("ready dropped");
	drv_enable_a: assert property (wr && od_index == 16'h2290 && od_subindex == 8'h00
		|=> ##1 drive_iface_en == $past(od_wdata[0], 2)) else $error("drive enable wrong");
	cmd_pulse_a: assert property (cmd_wr
		|=> drive_command_pulse && drive_command_byte == $past(od_wdata[7:0]))
		else $error("command pulse missing");
	pulse_cause_a: assert property (drive_command_pulse |-> $past(cmd_wr))
		else $error("stray command pulse");

	cover property (rd && od_index == 16'h2110);
	cover property (cmd_wr ##1 cmd_wr);
	cover property (od_ack && od_abort);
endmodule

bind fbs_regs fbs_regs_properties #(.CYCLES_PER_MS(CYCLES_PER_MS), .AVAIL_BITS(AVAIL_BITS),
	.DISABLE_MASK(DISABLE_MASK)) i_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.od_req(od_req), .od_write(od_write), .od_index(od_index), .od_subindex(od_subindex),
	.od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata),
	.bus_state_field(bus_state_field), .bus_error_in(bus_error_in),
	.clock_sync_in(clock_sync_in), .operational_ready(operational_ready),
	.fieldbus_enabled(fieldbus_enabled), .drive_iface_en(drive_iface_en),
	.drive_set_value1(drive_set_value1), .drive_set_value2(drive_set_value2),
	.drive_set_value3(drive_set_value3), .drive_command_byte(drive_command_byte),
	.drive_command_pulse(drive_command_pulse));
`default_nettype wire

// ==== fbs_regs_test.sv ====
// Self-checking testbench for the fieldbus dictionary bank.
`timescale 1ns/1ps
`default_nettype none

module fbs_regs_test;
	logic        clk_sys;
	logic        sys_rst;
	logic        od_req;
	logic        od_write;
	logic [15:0] od_index;
	logic [7:0]  od_subindex;
	logic [31:0] od_wdata;
	logic        od_ack;
	logic        od_abort;
	logic [31:0] od_rdata;
	logic [3:0]  bus_state;
	logic        bus_err;
	logic        sync_on;
	logic        ready;
	logic [31:0] enabled;
	logic        drv_en;
	logic [31:0] val1;
	logic [15:0] val2;
	logic [7:0]  val3;
	logic [7:0]  cmd_byte;
	logic        cmd_pulse;
	logic [2:0]  link_sel;
	logic        link_err;
	logic        link_sync;
	logic [31:0] rd;
	logic        ab;
	logic [3:0]  codes [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
	int          num_errors = 0;
	int          n_compared = 0;

	fbs_regs #(.CYCLES_PER_MS(4)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.od_req(od_req), .od_write(od_write), .od_index(od_index), .od_subindex(od_subindex),
		.od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata),
		.bus_state_field(bus_state), .bus_error_in(bus_err), .clock_sync_in(sync_on),
		.operational_ready(ready), .fieldbus_enabled(enabled), .drive_iface_en(drv_en),
		.drive_set_value1(val1), .drive_set_value2(val2), .drive_set_value3(val3),
		.drive_command_byte(cmd_byte), .drive_command_pulse(cmd_pulse));
	fbs_link_model i_link (.clk_sys(clk_sys), .sel(link_sel), .err(link_err), .sync(link_sync),
		.bus_state_field(bus_state), .bus_error_in(bus_err), .clock_sync_in(sync_on));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic results;
		if (num_errors == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One access: request for one edge, answer taken one cycle later.
	task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd);
		@(negedge clk_sys);
		od_req = 1'b1;
		od_write = w;
		od_index = idx;
		od_subindex = sub;
		od_wdata = wd;
		@(negedge clk_sys);
		od_req = 1'b0;
		chk({31'h0, od_ack}, 32'h1);
		ab = od_abort;
		rd = od_rdata;
	endtask

	task automatic rdchk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
		acc(1'b0, idx, sub, 32'h0);
		chk(rd, exp);
		chk({31'h0, ab}, 32'h0);
	endtask

	task automatic refused(input logic w, input logic [15:0] idx, input logic [7:0] sub);
		acc(w, idx, sub, 32'hFFFFFFFF);
		chk({31'h0, ab}, 32'h1);
		chk(rd, 32'h0);
	endtask

	task automatic do_reset;
		sys_rst = 1'b1;
		repeat (6) @(negedge clk_sys);
		chk({31'h0, ready}, 32'h0);
		chk(enabled, 32'h20);
		chk({31'h0, drv_en}, 32'h1);
		sys_rst = 1'b0;
		@(negedge clk_sys);
		chk({31'h0, ready}, 32'h1);
	endtask

	initial begin
		#100000;
		num_errors++;
		results;
	end

	initial begin
		{od_req, od_write, od_index, od_subindex, od_wdata} = '0;
		{link_sel, link_err, link_sync} = '0;
		do_reset;
		rdchk(16'h2084, 8'h00, 32'h0);
		rdchk(16'h2101, 8'h00, 32'h20);
		rdchk(16'h2102, 8'h00, 32'h20);
		rdchk(16'h2103, 8'h00, 32'h2);
		rdchk(16'h2103, 8'h01, 32'h0);
		rdchk(16'h2103, 8'h02, 32'h20);
		rdchk(16'h2290, 8'h00, 32'h1);
		rdchk(16'h2291, 8'h00, 32'h4);
		for (int i = 1; i < 5; i++) rdchk(16'h2291, 8'(i), 32'h0);
		acc(1'b1, 16'h2084, 8'h00, 32'hA5A5F00F);
		rdchk(16'h2084, 8'h00, 32'hA5A5F00F);
		chk({31'h0, ready}, 32'h1);
		acc(1'b1, 16'h2102, 8'h00, 32'hFFFFFFFF);
		rdchk(16'h2102, 8'h00, 32'h0007007F);
		acc(1'b1, 16'h2102, 8'h00, 32'h0);
		rdchk(16'h2103, 8'h02, 32'h20);
		chk(enabled, 32'h20);
		acc(1'b1, 16'h2290, 8'h00, 32'h0);
		@(negedge clk_sys);
		chk({31'h0, drv_en}, 32'h0);
		acc(1'b1, 16'h2290, 8'h00, 32'hFF);
		rdchk(16'h2290, 8'h00, 32'hFF);
		chk({31'h0, drv_en}, 32'h1);
		refused(1'b1, 16'h2101, 8'h00);
		refused(1'b1, 16'h2103, 8'h00);
		refused(1'b1, 16'h2103, 8'h01);
		refused(1'b1, 16'h2103, 8'h02);
		refused(1'b1, 16'h2110, 8'h00);
		refused(1'b1, 16'h2291, 8'h00);
		refused(1'b0, 16'h2100, 8'h00);
		refused(1'b0, 16'h2084, 8'h01);
		rdchk(16'h2101, 8'h00, 32'h20);
		for (int i = 0; i < 5; i++) begin
			link_sel = 3'(i);
			link_err = i[0];
			link_sync = i[1];
			repeat (3) @(negedge clk_sys);
			rdchk(16'h2110, 8'h00, {26'h0, link_sync, link_err, codes[i]});
		end
		acc(1'b1, 16'h2291, 8'h01, 32'h80000001);
		rdchk(16'h2291, 8'h01, 32'h80000001);
		chk(val1, 32'h80000001);
		acc(1'b1, 16'h2291, 8'h02, 32'h00008001);
		rdchk(16'h2291, 8'h02, 32'hFFFF8001);
		chk({16'h0, val2}, 32'h00008001);
		acc(1'b1, 16'h2291, 8'h03, 32'h00000080);
		rdchk(16'h2291, 8'h03, 32'hFFFFFF80);
		chk({24'h0, val3}, 32'h00000080);
		// Two identical commands back to back must each give a pulse.
		@(negedge clk_sys);
		{od_req, od_write, od_index, od_subindex, od_wdata} = {2'b11, 16'h2291, 8'h04, 32'hFB};
		repeat (2) begin
			@(negedge clk_sys);
			chk({23'h0, cmd_pulse, cmd_byte}, 32'h1FB);
		end
		od_req = 1'b0;
		@(negedge clk_sys);
		chk({31'h0, cmd_pulse}, 32'h0);
		rdchk(16'h2291, 8'h04, 32'hFFFFFFFB);
		do_reset;
		rdchk(16'h2084, 8'h00, 32'h0);
		rdchk(16'h2102, 8'h00, 32'h20);
		chk(val1, 32'h0);
		chk({16'h0, val2}, 32'h0);
		chk({24'h0, val3}, 32'h0);
		chk({24'h0, cmd_byte}, 32'h0);
		results;
	end
endmodule
`default_nettype wire
